// ==== gpc_gpio_port.sv ====
// GPIO port block: registers, pad control, pin sampling and port interrupts
//
// Behaviour
// - A pin in analog operation has its digital input buffer and output driver off.
// - Each pin chooses one of eight drive modes, from analog through weak both ways.
// - Each pin selects CMOS or LVTTL input thresholds for its digital input.
// - Input and output buffer enables are set per pin apart from the drive mode.
// - Each pin has a slow slew setting to limit its edge rate.
// - Pins form ports of up to eight, the two top ports having fewer pins.
// - During reset every pin has all buffers disabled.
// - A per-pin multiplexer picks which internal source drives the pin; every pin's sampled level goes to the peripherals.
// - A writable output value per pin is driven when software control is selected.
// - A readable per-pin state shows the sampled level on the pin.
// - A pin raises an interrupt only when its interrupt is enabled.
// - Pin interrupts merge into one request per port, four in all.
// - Pins used by the two-wire bus run open drain.
// - Only ports 0 to 2 have analog bus switches; the last port has none.
//
// Chosen here: the address-and-strobe port and the address map.
`default_nettype none
module gpc_gpio_port
  import gpc_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Register port
  input wire logic [gpc_pkg::AW-1:0] ADDR,
  input wire logic [gpc_pkg::DW-1:0] WDATA,
  input wire logic WE,
  input wire logic RE,
  output logic [gpc_pkg::DW-1:0] RDATA,
  // Pads
  input wire logic [gpc_pkg::NPIN-1:0] PAD_IN,
  output gpc_pkg::gpc_pad_ctl_t [gpc_pkg::NPIN-1:0] PAD_CTL,
  // Peripheral routing
  input wire logic [gpc_pkg::NPIN-1:0] PERIPH_OUT,
  input wire logic [gpc_pkg::NPIN-1:0] SERIAL_OUT,
  output logic [gpc_pkg::NPIN-1:0] PERIPH_IN,
  // Interrupts
  output logic [gpc_pkg::NPORT-1:0] IRQ_PORT,
  output logic IRQ
);
  import gpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [PW-1:0] impl_of(input logic [NPIN-1:0] m, input int p);
    impl_of = m[p*PW +: PW];
  endfunction

  // Per-pin mask widened to a field width
  function automatic logic [DW-1:0] widen(input logic [PW-1:0] m, input int fw);
    logic [DW-1:0] r;
    r = '0;
    for (int i = 0; i < PW; i++) begin
      for (int j = 0; j < fw; j++) begin
        r[i*fw+j] = m[i];
      end
    end
    widen = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // Four per-pin fields of one byte each share the configuration word
  if (DW < 4 * PW) begin : g_bad_dw
    $error("gpc_gpio_port: data word too narrow for the configuration fields");
  end
  // Register, port and unmapped bits must not overlap
  if (REG_LSB + 3 > PORT_LSB) begin : g_bad_reg
    $error("gpc_gpio_port: register field runs into the port field");
  end
  if (AW < PORT_LSB + 3) begin : g_bad_aw
    $error("gpc_gpio_port: address too narrow for the port field");
  end
  // The port field is two bits wide
  if (NPORT != 4 || NPIN != NPORT * PW) begin : g_bad_port
    $error("gpc_gpio_port: port count does not fit the port field");
  end
  if (PW * DM_W > DW || PW * SEL_W > DW) begin : g_bad_fields
    $error("gpc_gpio_port: per-pin fields wider than the data word");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [PW-1:0] out_ff [NPORT];
  logic [PW*DM_W-1:0] drive_ff [NPORT];
  logic [DW-1:0] cfg_ff [NPORT];
  logic [PW*SEL_W-1:0] sel_ff [NPORT];
  logic [PW-1:0] mask_ff [NPORT];
  logic [PW-1:0] amux_ff [NPORT];
  logic [PW-1:0] nxt_out [NPORT];
  logic [PW*DM_W-1:0] nxt_drive [NPORT];
  logic [DW-1:0] nxt_cfg [NPORT];
  logic [PW*SEL_W-1:0] nxt_sel [NPORT];
  logic [PW-1:0] nxt_mask [NPORT];
  logic [PW-1:0] nxt_amux [NPORT];

  logic [DW-1:0] rdata_ff;
  logic [DW-1:0] nxt_rdata;
  logic [NPIN-1:0] state_ff;
  logic [NPIN-1:0] nxt_state;
  gpc_pad_ctl_t [NPIN-1:0] pad_ff;
  gpc_pad_ctl_t [NPIN-1:0] nxt_pad;
  logic [NPORT-1:0] irq_port_ff;
  logic [NPORT-1:0] nxt_irq_port;
  logic irq_ff;
  logic nxt_irq;

  logic hit;
  logic [1:0] port_sel;
  logic [2:0] reg_sel;
  logic [NPORT-1:0] stat_clr;
  logic [PW-1:0] stat [NPORT];
  logic [NPORT-1:0] req;
  gpc_pin_cfg_t [NPIN-1:0] pin_cfg;
  gpc_pad_ctl_t [NPIN-1:0] pad_comb;

  assign hit = ~ADDR[AW-1];
  assign port_sel = ADDR[PORT_LSB +: 2];
  assign reg_sel = ADDR[REG_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      nxt_out[p] = out_ff[p];
      nxt_drive[p] = drive_ff[p];
      nxt_cfg[p] = cfg_ff[p];
      nxt_sel[p] = sel_ff[p];
      nxt_mask[p] = mask_ff[p];
      nxt_amux[p] = amux_ff[p];
      // Bits of missing pins stay zero so software can probe the port width
      if (WE && hit && port_sel == 2'(p)) begin
        unique case (reg_sel)
          REG_OUT: nxt_out[p] = WDATA[PW-1:0] & impl_of(PIN_IMPL, p);
          REG_DRIVE: nxt_drive[p] = WDATA[PW*DM_W-1:0] & (PW*DM_W)'(widen(impl_of(PIN_IMPL, p), DM_W));
          REG_CFG: nxt_cfg[p] = WDATA & {4{impl_of(PIN_IMPL, p)}};
          REG_SEL: nxt_sel[p] = WDATA[PW*SEL_W-1:0] & (PW*SEL_W)'(widen(impl_of(PIN_IMPL, p), SEL_W));
          REG_MASK: nxt_mask[p] = WDATA[PW-1:0] & impl_of(PIN_IMPL, p);
          REG_AMUX: nxt_amux[p] = WDATA[PW-1:0] & impl_of(AMUX_IMPL, p);
          REG_IN, REG_STAT: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int p = 0; p < NPORT; p++) begin
        out_ff[p] <= RST_BYTE;
        drive_ff[p] <= RST_DRIVE;
        cfg_ff[p] <= RST_CFG;
        sel_ff[p] <= RST_SEL;
        mask_ff[p] <= RST_BYTE;
        amux_ff[p] <= RST_BYTE;
      end
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        out_ff[p] <= nxt_out[p];
        drive_ff[p] <= nxt_drive[p];
        cfg_ff[p] <= nxt_cfg[p];
        sel_ff[p] <= nxt_sel[p];
        mask_ff[p] <= nxt_mask[p];
        amux_ff[p] <= nxt_amux[p];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads; a status read clears that port's flags

  always_comb begin
    nxt_rdata = '0;
    stat_clr = '0;
    if (RE && hit) begin
      unique case (reg_sel)
        REG_OUT: nxt_rdata[PW-1:0] = out_ff[port_sel];
        REG_IN: nxt_rdata[PW-1:0] = state_ff[port_sel*PW +: PW];
        REG_DRIVE: nxt_rdata[PW*DM_W-1:0] = drive_ff[port_sel];
        REG_CFG: nxt_rdata = cfg_ff[port_sel];
        REG_SEL: nxt_rdata[PW*SEL_W-1:0] = sel_ff[port_sel];
        REG_STAT: begin
          nxt_rdata[PW-1:0] = stat[port_sel];
          stat_clr[port_sel] = 1'b1;
        end
        REG_MASK: nxt_rdata[PW-1:0] = mask_ff[port_sel];
        REG_AMUX: nxt_rdata[PW-1:0] = amux_ff[port_sel];
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad control

  // One process for all pins keeps a single writer of the config vector
  always_comb begin
    for (int n = 0; n < NPIN; n++) begin
      pin_cfg[n].dm = gpc_drive_t'(drive_ff[n/PW][(n%PW)*DM_W +: DM_W]);
      pin_cfg[n].src = gpc_src_t'(sel_ff[n/PW][(n%PW)*SEL_W +: SEL_W]);
      pin_cfg[n].ie = cfg_ff[n/PW][CFG_IE_LSB + n%PW];
      pin_cfg[n].oe = cfg_ff[n/PW][CFG_OE_LSB + n%PW];
      pin_cfg[n].lvttl = cfg_ff[n/PW][CFG_LVTTL_LSB + n%PW];
      pin_cfg[n].slow = cfg_ff[n/PW][CFG_SLOW_LSB + n%PW];
      pin_cfg[n].amux = amux_ff[n/PW][n%PW];
    end
  end

  for (genvar n = 0; n < NPIN; n++) begin : g_pin
    gpc_pad_cell u_cell (
      .cfg(pin_cfg[n]),
      .sw_out(out_ff[n/PW][n%PW]),
      .periph_out(PERIPH_OUT[n]),
      .serial_out(SERIAL_OUT[n]),
      .ctl(pad_comb[n])
    );
  end

  always_comb begin
    for (int n = 0; n < NPIN; n++) begin
      nxt_pad[n] = PIN_IMPL[n] ? pad_comb[n] : '0;
    end
  end

  // Reset clears every pad control: outputs off, inputs off, no pulls
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pad_ff <= '0;
    end else begin
      pad_ff <= nxt_pad;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling; a disabled input buffer reads as zero

  always_comb begin
    for (int n = 0; n < NPIN; n++) begin
      nxt_state[n] = PAD_IN[n] & pad_ff[n].ie & PIN_IMPL[n];
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port interrupts

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    gpc_irq_unit #(
      .W(PW)
    ) u_irq (
      .clk(CLK),
      .rst_n(RESETN),
      .pin_state(state_ff[p*PW +: PW]),
      .mask(mask_ff[p]),
      .clr(stat_clr[p]),
      .stat(stat[p]),
      .req(req[p])
    );
  end

  always_comb begin
    nxt_irq_port = req;
    nxt_irq = |req;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      irq_port_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      irq_port_ff <= nxt_irq_port;
      irq_ff <= nxt_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign RDATA = rdata_ff;
  assign PAD_CTL = pad_ff;
  assign PERIPH_IN = state_ff;
  assign IRQ_PORT = irq_port_ff;
  assign IRQ = irq_ff;
endmodule
`default_nettype wire

// ==== gpc_pkg.sv ====
// Shared constants, types and register map of the GPIO port block
`default_nettype none
package gpc_pkg;
  localparam int NPORT = 4;
  localparam int PW = 8;
  localparam int NPIN = NPORT * PW;
  localparam int AW = 8;
  localparam int DW = 32;

  // Pins that exist: ports 0 and 1 full, port 2 one pin, port 3 three pins
  localparam logic [NPIN-1:0] PIN_IMPL = 32'h0701FFFF;
  // Pins with analog bus switches: ports 0 to 2 only
  localparam logic [NPIN-1:0] AMUX_IMPL = 32'h0001FFFF;

  // Address split: ADDR[7] must be 0, ADDR[6:5] port, ADDR[4:2] register
  localparam int PORT_LSB = 5;
  localparam int REG_LSB = 2;
  localparam logic [2:0] REG_OUT = 3'h0;
  localparam logic [2:0] REG_IN = 3'h1;
  localparam logic [2:0] REG_DRIVE = 3'h2;
  localparam logic [2:0] REG_CFG = 3'h3;
  localparam logic [2:0] REG_SEL = 3'h4;
  localparam logic [2:0] REG_STAT = 3'h5;
  localparam logic [2:0] REG_MASK = 3'h6;
  localparam logic [2:0] REG_AMUX = 3'h7;

  // Field positions inside the configuration word
  localparam int CFG_IE_LSB = 0;
  localparam int CFG_OE_LSB = 8;
  localparam int CFG_LVTTL_LSB = 16;
  localparam int CFG_SLOW_LSB = 24;
  localparam int DM_W = 3;
  localparam int SEL_W = 2;

  // Reset values: every pin analog, all buffers off
  localparam logic [PW*DM_W-1:0] RST_DRIVE = 24'h000000;
  localparam logic [DW-1:0] RST_CFG = 32'h00000000;
  localparam logic [PW*SEL_W-1:0] RST_SEL = 16'h0000;
  localparam logic [PW-1:0] RST_BYTE = 8'h00;

  typedef enum logic [2:0] {
    DM_ANALOG = 3'h0,
    DM_INPUT = 3'h1,
    DM_WUP_SDN = 3'h2,
    DM_SUP_WDN = 3'h3,
    DM_OD_LOW = 3'h4,
    DM_OD_HIGH = 3'h5,
    DM_STRONG = 3'h6,
    DM_WEAK = 3'h7
  } gpc_drive_t;

  typedef enum logic [1:0] {
    SRC_SW = 2'h0,
    SRC_PERIPH = 2'h1,
    SRC_SERIAL = 2'h2,
    SRC_ANALOG = 2'h3
  } gpc_src_t;

  typedef struct packed {
    gpc_drive_t dm;
    gpc_src_t src;
    logic ie;
    logic oe;
    logic lvttl;
    logic slow;
    logic amux;
  } gpc_pin_cfg_t;

  typedef struct packed {
    logic out;
    logic oe;
    logic pu;
    logic pd;
    logic ie;
    logic lvttl;
    logic slow;
    logic amux;
  } gpc_pad_ctl_t;
endpackage
`default_nettype wire

// ==== gpc_pad_cell.sv ====
// Per-pin drive decoder: drive mode and source select to pad controls
`default_nettype none
module gpc_pad_cell
  import gpc_pkg::*;
(
  // Configuration
  input wire gpc_pkg::gpc_pin_cfg_t cfg,
  // Data sources
  input wire logic sw_out,
  input wire logic periph_out,
  input wire logic serial_out,
  // Pad controls
  output gpc_pkg::gpc_pad_ctl_t ctl
);
  gpc_drive_t dm_eff;
  logic data;
  logic analog;
  logic strong_hi;
  logic strong_lo;
  logic weak_hi;
  logic weak_lo;

  always_comb begin
    // Two-wire bus pins are always open drain, whatever software chose
    dm_eff = (cfg.src == SRC_SERIAL) ? DM_OD_LOW : cfg.dm;
    unique case (cfg.src)
      SRC_SW: data = sw_out;
      SRC_PERIPH: data = periph_out;
      SRC_SERIAL: data = serial_out;
      SRC_ANALOG: data = 1'b0;
    endcase
    analog = (dm_eff == DM_ANALOG) || (cfg.src == SRC_ANALOG);
    strong_hi = 1'b0;
    strong_lo = 1'b0;
    weak_hi = 1'b0;
    weak_lo = 1'b0;
    unique case (dm_eff)
      DM_ANALOG, DM_INPUT: begin
      end
      DM_WUP_SDN: begin
        strong_lo = ~data;
        weak_hi = data;
      end
      DM_SUP_WDN: begin
        strong_hi = data;
        weak_lo = ~data;
      end
      DM_OD_LOW: strong_lo = ~data;
      DM_OD_HIGH: strong_hi = data;
      DM_STRONG: begin
        strong_hi = data;
        strong_lo = ~data;
      end
      DM_WEAK: begin
        weak_hi = data;
        weak_lo = ~data;
      end
    endcase
    // Output and input buffer enables gate every drive mode
    ctl.out = data;
    ctl.oe = (strong_hi | strong_lo) & cfg.oe & ~analog;
    ctl.pu = weak_hi & cfg.oe & ~analog;
    ctl.pd = weak_lo & cfg.oe & ~analog;
    ctl.ie = cfg.ie & ~analog;
    ctl.lvttl = cfg.lvttl;
    ctl.slow = cfg.slow;
    ctl.amux = cfg.amux;
  end
endmodule
`default_nettype wire

// ==== gpc_irq_unit.sv ====
// Per-port pin-change flags with read-to-clear and masked request
`default_nettype none
module gpc_irq_unit
  import gpc_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin levels and software side
  input wire logic [W-1:0] pin_state,
  input wire logic [W-1:0] mask,
  input wire logic clr,
  // Flags and request
  output logic [W-1:0] stat,
  output logic req
);
  logic [W-1:0] prev_ff;
  logic [W-1:0] stat_ff;
  logic [W-1:0] nxt_prev;
  logic [W-1:0] nxt_stat;

  if (W < 1 || W > 32) begin : g_bad_w
    $error("gpc_irq_unit: W out of range");
  end

  always_comb begin
    nxt_prev = pin_state;
    // A change seen in the clearing cycle survives the clear
    nxt_stat = (clr ? '0 : stat_ff) | (pin_state ^ prev_ff);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= '0;
      stat_ff <= '0;
    end else begin
      prev_ff <= nxt_prev;
      stat_ff <= nxt_stat;
    end
  end

  assign stat = stat_ff;
  assign req = |(stat_ff & mask);
endmodule
`default_nettype wire

// ==== gpc_gpio_port_assertions.sv ====
// Port-level assertions for the GPIO port block
`default_nettype none
module gpc_gpio_port_checker
  import gpc_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Register port
  input wire logic WE,
  input wire logic RE,
  input wire logic [gpc_pkg::DW-1:0] RDATA,
  // Pads and requests
  input wire logic [gpc_pkg::NPIN-1:0] PAD_IN,
  input wire gpc_pkg::gpc_pad_ctl_t [gpc_pkg::NPIN-1:0] PAD_CTL,
  input wire logic [gpc_pkg::NPIN-1:0] PERIPH_IN,
  input wire logic [gpc_pkg::NPORT-1:0] IRQ_PORT,
  input wire logic IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NPIN-1:0] ie_v;
  logic [NPIN-1:0] seen_v;
  logic [NPIN-1:0] amux_v;
  logic [NPIN-1:0] any_v;
  logic [NPIN-1:0] pull_bad;

  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      ie_v[i] = PAD_CTL[i].ie;
      amux_v[i] = PAD_CTL[i].amux;
      any_v[i] = |PAD_CTL[i];
      // A weak pull must agree with the data it stands for
      pull_bad[i] = (PAD_CTL[i].pu & ~PAD_CTL[i].out) | (PAD_CTL[i].pd & PAD_CTL[i].out);
    end
    seen_v = PAD_IN & ie_v;
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  ////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!RE |=> RDATA == '0)
    else $error("read data outside read slot");
  a_reset_off: assert property (
    $rose(RESETN) |-> PAD_CTL == '0 && IRQ_PORT == '0) else $error("pads active after reset");
  a_pin_state: assert property (
    PERIPH_IN == $past(seen_v)) else $error("pin state not sampled pad");
  a_missing_pins: assert property (
    (any_v & ~PIN_IMPL) == '0) else $error("missing pin has active control");
  a_amux_last: assert property (
    (amux_v & ~AMUX_IMPL) == '0) else $error("analog switch on pin without one");
  a_pull_data: assert property (
    pull_bad == '0) else $error("pull disagrees with data");
  a_irq_any: assert property (
    IRQ == |IRQ_PORT) else $error("summary request differs from port requests");
  a_irq_hold: assert property (
    !$past(RE) && !$past(WE) |=> ($past(IRQ_PORT) & ~IRQ_PORT) == '0) else $error("request dropped");
  a_irq_cause: assert property (
    $rose(IRQ) |-> $past(PERIPH_IN, 2) != $past(PERIPH_IN, 3) || $past(WE, 2))
    else $error("request rose without pin change");
endmodule

bind gpc_gpio_port gpc_gpio_port_checker u_chk (.CLK(CLK), .RESETN(RESETN), .WE(WE), .RE(RE), .RDATA(RDATA),
  .PAD_IN(PAD_IN), .PAD_CTL(PAD_CTL), .PERIPH_IN(PERIPH_IN), .IRQ_PORT(IRQ_PORT), .IRQ(IRQ));
`default_nettype wire

// ==== gpc_pad_model.sv ====
// Board-side pad model: resolves each pad level
`default_nettype none
module gpc_pad_model
  import gpc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Controls and board sources
  input wire gpc_pkg::gpc_pad_ctl_t [gpc_pkg::NPIN-1:0] pad_ctl,
  input wire logic [gpc_pkg::NPIN-1:0] ext_en,
  input wire logic [gpc_pkg::NPIN-1:0] ext_val,
  // Pad levels
  output logic [gpc_pkg::NPIN-1:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic float_ff = 1'b0;

  // Floating pads wander so a stale level never passes for a driven one
  always_ff @(posedge clk) begin
    float_ff <= ~float_ff;
  end

  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pad_ctl[i].oe) begin
        pad_in[i] = pad_ctl[i].out;
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pad_ctl[i].pu | pad_ctl[i].pd) begin
        pad_in[i] = pad_ctl[i].pu;
      end else begin
        pad_in[i] = float_ff;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb_gpc_gpio_port.sv ====
// Self-checking bench for the GPIO port block
`default_nettype none
module tb_gpc_gpio_port;
  timeunit 1ns;
  timeprecision 1ps;
  import gpc_pkg::*;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic [AW-1:0] ADDR = '0;
  logic [DW-1:0] WDATA = '0;
  logic [DW-1:0] RDATA;
  logic WE = 1'b0;
  logic RE = 1'b0;
  logic IRQ;
  logic [NPIN-1:0] PAD_IN;
  logic [NPIN-1:0] PERIPH_IN;
  logic [NPIN-1:0] PERIPH_OUT = '0;
  logic [NPIN-1:0] SERIAL_OUT = '0;
  logic [NPIN-1:0] ext_en = '0;
  logic [NPIN-1:0] ext_val = '0;
  gpc_pad_ctl_t [NPIN-1:0] PAD_CTL;
  logic [NPORT-1:0] IRQ_PORT;
  int bad_count = 0;
  int checked = 0;

  gpc_gpio_port u_dut (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WE(WE), .RE(RE), .RDATA(RDATA),
    .PAD_IN(PAD_IN), .PAD_CTL(PAD_CTL), .PERIPH_OUT(PERIPH_OUT), .SERIAL_OUT(SERIAL_OUT),
    .PERIPH_IN(PERIPH_IN), .IRQ_PORT(IRQ_PORT), .IRQ(IRQ));
  gpc_pad_model u_pads (.clk(CLK), .pad_ctl(PAD_CTL), .ext_en(ext_en), .ext_val(ext_val), .pad_in(PAD_IN));

  initial begin
    forever #4 CLK = ~CLK;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WE <= 1'b1;
    @(posedge CLK);
    WE <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RE <= 1'b1;
    @(posedge CLK);
    RE <= 1'b0;
    #1 check(RDATA, exp);
  endtask

  // Drive, pulls and input enable of one pad; its data only while it drives
  task automatic chk_pin(input int n, input logic [3:0] exp, input logic d);
    @(posedge CLK);
    #1 check({PAD_CTL[n].oe, PAD_CTL[n].pu, PAD_CTL[n].pd, PAD_CTL[n].ie}, exp);
    if (exp[3]) begin
      check(PAD_CTL[n].out, d);
    end
  endtask

  task automatic wait_irq(input int p, input logic v);
    int i;
    for (i = 0; i < 10 && IRQ_PORT[p] !== v; i++) begin
      @(posedge CLK);
      #1;
    end
    if (i == 10) begin
      bad_count++;
      $display("Error at %0t: port request stuck", $time);
      test_done;
    end
  endtask

  // {oe, pu, pd, ie} per drive mode and data
  function automatic logic [3:0] exp_mode(input int m, input logic d);
    case (m)
      0: return 4'h0;
      1: return 4'h1;
      2: return {~d, d, 2'h1};
      3: return {d, 1'b0, ~d, 1'b1};
      4: return {~d, 3'h1};
      5: return {d, 3'h1};
      6: return 4'h9;
      default: return {1'b0, d, ~d, 1'b1};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge CLK);
    check(|PAD_CTL, 1'b0);
    RESETN <= 1'b1;
    for (int r = 0; r < 8; r++) begin
      rd(8'(r * 4), 32'h0);
    end
    // Unmapped write must not alias onto port 0
    wr(8'h80, 32'hFFFFFFFF);
    rd(8'h80, 32'h0);
    rd(8'h00, 32'h0);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h1);
    wr(8'h60, 32'hFFFFFFFF);
    rd(8'h60, 32'h7);
    wr(8'h7C, 32'hFFFFFFFF);
    rd(8'h7C, 32'h0);
    wr(8'h1C, 32'h1);
    @(posedge CLK);
    #1 check(PAD_CTL[0].amux, 1'b1);
    wr(8'h1C, 32'h0);
    wr(8'h0C, 32'h01010101);
    for (int m = 0; m < 8; m++) begin
      wr(8'h08, 32'(m));
      for (int d = 0; d < 2; d++) begin
        wr(8'h00, 32'(d));
        chk_pin(0, exp_mode(m, d[0]), d[0]);
      end
    end
    check({PAD_CTL[0].lvttl, PAD_CTL[0].slow}, 2'h3);
    wr(8'h08, 32'h6);
    wr(8'h00, 32'h0);
    wr(8'h0C, 32'h00000101);
    chk_pin(0, 4'h9, 1'b0);
    check({PAD_CTL[0].lvttl, PAD_CTL[0].slow}, 2'h0);
    wr(8'h0C, 32'h00000001);
    chk_pin(0, 4'h1, 1'b0);
    wr(8'h0C, 32'h00000100);
    chk_pin(0, 4'h8, 1'b0);
    wr(8'h0C, 32'h00000101);
    PERIPH_OUT <= 32'h1;
    wr(8'h10, 32'h1);
    chk_pin(0, 4'h9, 1'b1);
    wr(8'h10, 32'h2);
    chk_pin(0, 4'h9, 1'b0);
    @(posedge CLK) SERIAL_OUT <= 32'h1;
    chk_pin(0, 4'h1, 1'b1);
    wr(8'h10, 32'h3);
    chk_pin(0, 4'h0, 1'b0);
    // Pin 0 of port 1 held low by the board, then toggled
    @(posedge CLK) ext_en <= 32'h100;
    wr(8'h28, 32'h1);
    wr(8'h2C, 32'h1);
    wr(8'h38, 32'h1);
    repeat (4) @(posedge CLK);
    rd(8'h34, 32'h0);
    @(posedge CLK) ext_val <= 32'h100;
    wait_irq(1, 1'b1);
    check(IRQ, 1'b1);
    check(PERIPH_IN, 32'h100);
    rd(8'h24, 32'h1);
    check(IRQ_PORT, 4'h2);
    rd(8'h34, 32'h1);
    wait_irq(1, 1'b0);
    rd(8'h34, 32'h0);
    wr(8'h38, 32'h0);
    @(posedge CLK) ext_val <= 32'h0;
    repeat (6) @(posedge CLK);
    #1 check(IRQ_PORT, 4'h0);
    rd(8'h34, 32'h1);
    @(posedge CLK) RESETN <= 1'b0;
    @(posedge CLK);
    #1 check(|PAD_CTL, 1'b0);
    @(posedge CLK) RESETN <= 1'b1;
    rd(8'h0C, 32'h0);
    test_done;
  end
endmodule
`default_nettype wire
